// File: rtl/ebp_pkg.sv
/*
 ebp_pkg: constants shared by the array end, the controller end and the timer.
 Assumes a single 250 MHz clock and an 8-bit memory bus with a 16-bit address.
*/
package ebp_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// array placement and block layout
	localparam int AIDX_W = 10;
	localparam int ARRAY_BYTES = 1024;
	localparam int ARRAY_TAG_W = 6;
	localparam logic [ARRAY_TAG_W-1:0] ARRAY_TAG = 6'h02;
	localparam int BLK_SHIFT = 8;
	localparam int BLK_CNT = 4;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'hFF7B;
	localparam logic [ADDR_W-1:0] NVR_ADDR = 16'hFF7A;
	// array_control_register bit positions
	localparam int BIT_PGM = 0;
	localparam int BIT_LAT = 1;
	localparam int BIT_ERL = 2;
	localparam int BIT_ERH = 3;
	localparam int BIT_AUTO = 4;
	localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] NVR_RESET = 8'hFF;
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROGRAM_TIME_NS = 10000;
	localparam int VOLTAGE_FALL_TIME_NS = 1000;
	localparam int TMR_W = 12;
	localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;
	localparam logic [TMR_W-1:0] PROGRAM_CYCLES =
		TMR_W'((PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// the automatic stop must come before the nominal program time
	localparam logic [TMR_W-1:0] AUTO_CYCLES = TMR_W'((PROGRAM_TIME_NS * 7) / (CLK_PERIOD_NS * 8));
	localparam logic [TMR_W-1:0] FALL_CYCLES =
		TMR_W'((VOLTAGE_FALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// controller software registers
	localparam int SW_ADDR_W = 2;
	localparam int SW_DATA_W = 16;
	localparam logic [SW_ADDR_W-1:0] SW_TARGET = 2'h0;
	localparam logic [SW_ADDR_W-1:0] SW_DATA = 2'h1;
	localparam logic [SW_ADDR_W-1:0] SW_CMD = 2'h2;
	localparam logic [SW_ADDR_W-1:0] SW_STATUS = 2'h3;
	localparam int CMD_GO = 0;
	localparam int CMD_AUTO = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	typedef enum logic [9:0] {
		HS_IDLE = 10'h001,
		HS_DATA = 10'h002,
		HS_PGM = 10'h004,
		HS_WAITP = 10'h008,
		HS_WAITF = 10'h010,
		HS_POLL = 10'h020,
		HS_POLLW = 10'h040,
		HS_POLLR = 10'h080,
		HS_CLRL = 10'h100,
		HS_END = 10'h200
	} ebp_hstate_e;
endpackage : ebp_pkg

// File: rtl/ebp_if.sv
/*
 ebp_if: the internal memory bus between the controller and the array end.
 Assumes both ends run on the same clock; read data follow a read by one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface ebp_if;
	logic [ebp_pkg::ADDR_W-1:0] addr;
	logic [ebp_pkg::DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic [ebp_pkg::DATA_W-1:0] rdata;
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport cpu (output addr, output wdata, output wr, output rd, input rdata);
endinterface : ebp_if
`default_nettype wire

// File: rtl/ebp_timer.sv
/*
 ebp_timer: one-shot down counter; done pulses len cycles after load.
 Assumes load and abort come from logic on mclk; len is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module ebp_timer (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic load,
	input wire logic abort,
	input wire logic [ebp_pkg::TMR_W-1:0] len,
	output logic done
);
	logic [ebp_pkg::TMR_W-1:0] cnt_r;
	logic [ebp_pkg::TMR_W-1:0] cnt_nxt;
	logic run_r;
	logic run_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		done_nxt = 1'b0;
		if (abort) begin
			run_nxt = 1'b0;
		end else if (load) begin
			cnt_nxt = len;
			run_nxt = 1'b1;
		end else if (run_r) begin
			if (cnt_r == ebp_pkg::TMR_ONE) begin
				run_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - ebp_pkg::TMR_ONE;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
endmodule : ebp_timer
`default_nettype wire

// File: rtl/ebp_dev.sv
/*
 ebp_dev: byte-programming sequencer of the second array, with the array itself.
 Assumes the CPU bus on mclk, one strobe per cycle, and blk_protect from mclk logic.
*/
// Function
// R01: software clears erase bits, sets latch enable
// R02: auto mode chosen in the latch step
// R03: capture only writes to valid array addresses
// R04: later valid writes replace captured values
// R05: array read returns latch, captures read address
// R06: software reads only the written location
// R07: control writes accepted after valid capture
// R08: program enable refused without latch, valid address
// R09: program enable starts high voltage sequence
// R10: array read during programming fails cycle
// R11: manual: wait, clear program, wait, clear latch
// R12: auto timer clears program enable; software polls
// R13: auto clear comes before nominal program time
// R14: clearing both bits clears program only
// R15: programming only turns ones into zeros
// R16: only unprotected blocks and config programmable
// R17: software never reprograms a zero bit
// R18: writes outside array keep captured values
`timescale 1ns/1ps
`default_nettype none
module ebp_dev (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	ebp_if.dev bus,
	input wire logic [ebp_pkg::BLK_CNT-1:0] blk_protect,
	output logic hv_on,
	output logic prog_done,
	output logic prog_fail,
	output logic [ebp_pkg::DATA_W-1:0] nv_config
);
	localparam int DW = ebp_pkg::DATA_W;
	localparam int AW = ebp_pkg::ADDR_W;

	logic [DW-1:0] mem_r [0:ebp_pkg::ARRAY_BYTES-1];
	logic latch_r, latch_nxt;
	logic pgm_r, pgm_nxt;
	logic auto_r, auto_nxt;
	logic erl_r, erl_nxt;
	logic erh_r, erh_nxt;
	logic [AW-1:0] lat_addr_r, lat_addr_nxt;
	logic [DW-1:0] lat_data_r, lat_data_nxt;
	logic lat_valid_r, lat_valid_nxt;
	logic fail_r, fail_nxt;
	logic [DW-1:0] rdata_r, rdata_nxt;
	logic done_r, done_nxt;
	logic failout_r, failout_nxt;
	logic tend_r, tend_nxt;
	logic [DW-1:0] nvr_r, nvr_nxt;
	logic mem_we;
	logic tmr_load;
	logic tmr_abort;
	logic tmr_done;
	logic in_arr;
	logic in_nvr;
	logic in_ctl;
	logic lat_in_arr;
	logic lat_in_nvr;
	logic lat_prot;
	logic [ebp_pkg::AIDX_W-1:0] bus_idx;
	logic [ebp_pkg::AIDX_W-1:0] lat_idx;
	logic [DW-1:0] ctl_byte;

	assign bus_idx = bus.addr[ebp_pkg::AIDX_W-1:0];
	assign lat_idx = lat_addr_r[ebp_pkg::AIDX_W-1:0];
	assign in_arr = (bus.addr[AW-1:ebp_pkg::AIDX_W] == ebp_pkg::ARRAY_TAG);
	assign in_nvr = (bus.addr == ebp_pkg::NVR_ADDR);
	assign in_ctl = (bus.addr == ebp_pkg::CTRL_ADDR);
	assign lat_in_arr = (lat_addr_r[AW-1:ebp_pkg::AIDX_W] == ebp_pkg::ARRAY_TAG);
	assign lat_in_nvr = (lat_addr_r == ebp_pkg::NVR_ADDR);
	assign lat_prot = blk_protect[lat_idx[ebp_pkg::AIDX_W-1:ebp_pkg::BLK_SHIFT]];

	always_comb begin
		ctl_byte = ebp_pkg::ZERO_BYTE;
		ctl_byte[ebp_pkg::BIT_PGM] = pgm_r;
		ctl_byte[ebp_pkg::BIT_LAT] = latch_r;
		ctl_byte[ebp_pkg::BIT_ERL] = erl_r;
		ctl_byte[ebp_pkg::BIT_ERH] = erh_r;
		ctl_byte[ebp_pkg::BIT_AUTO] = auto_r;
	end

	ebp_timer u_timer (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.load(tmr_load),
		.abort(tmr_abort),
		.len(ebp_pkg::AUTO_CYCLES), // R13
		.done(tmr_done)
	);

	always_comb begin
		latch_nxt = latch_r;
		pgm_nxt = pgm_r;
		auto_nxt = auto_r;
		erl_nxt = erl_r;
		erh_nxt = erh_r;
		lat_addr_nxt = lat_addr_r;
		lat_data_nxt = lat_data_r;
		lat_valid_nxt = lat_valid_r;
		fail_nxt = fail_r;
		rdata_nxt = rdata_r;
		done_nxt = 1'b0;
		failout_nxt = failout_r;
		tend_nxt = tend_r;
		nvr_nxt = nvr_r;
		mem_we = 1'b0;
		tmr_load = 1'b0;
		tmr_abort = 1'b0;
		if (bus.wr && in_ctl) begin
			if (!latch_r) begin
				// a fresh latch step; program enable cannot ride along
				latch_nxt = bus.wdata[ebp_pkg::BIT_LAT]; // R08
				auto_nxt = bus.wdata[ebp_pkg::BIT_AUTO];
				erl_nxt = bus.wdata[ebp_pkg::BIT_ERL];
				erh_nxt = bus.wdata[ebp_pkg::BIT_ERH];
				lat_valid_nxt = 1'b0;
			end else if (lat_valid_r) begin
				auto_nxt = bus.wdata[ebp_pkg::BIT_AUTO]; // R07
				erl_nxt = bus.wdata[ebp_pkg::BIT_ERL];
				erh_nxt = bus.wdata[ebp_pkg::BIT_ERH];
				if (bus.wdata[ebp_pkg::BIT_PGM] && !pgm_r) begin
					pgm_nxt = 1'b1; // R09
					fail_nxt = 1'b0;
					tend_nxt = 1'b0;
					tmr_load = 1'b1;
				end else if (!bus.wdata[ebp_pkg::BIT_PGM] && pgm_r) begin
					pgm_nxt = 1'b0; // R11
					if (!tend_r) begin
						// cut short by software before the cell was fully written
						tmr_abort = 1'b1;
						done_nxt = 1'b1;
						failout_nxt = 1'b1;
					end
				end
				// latch stays while high voltage is still up
				if (!bus.wdata[ebp_pkg::BIT_LAT] && !pgm_r) begin
					latch_nxt = 1'b0; // R14
				end
			end else if (!bus.wdata[ebp_pkg::BIT_LAT]) begin
				// before a valid capture only abandoning the latch is honoured
				latch_nxt = 1'b0;
			end
		end
		if (bus.wr && latch_r && !pgm_r && (in_arr || in_nvr)) begin
			lat_addr_nxt = bus.addr; // R03 R04 R18
			lat_data_nxt = bus.wdata;
			lat_valid_nxt = 1'b1;
		end
		if (bus.rd) begin
			if (in_arr || in_nvr) begin
				if (latch_r) begin
					rdata_nxt = lat_data_r; // R05
					lat_addr_nxt = bus.addr;
					if (pgm_r) begin
						fail_nxt = 1'b1; // R10
					end
				end else if (in_arr) begin
					rdata_nxt = mem_r[bus_idx];
				end else begin
					rdata_nxt = nvr_r;
				end
			end else if (in_ctl) begin
				rdata_nxt = ctl_byte;
			end else begin
				rdata_nxt = ebp_pkg::ZERO_BYTE;
			end
		end
		if (pgm_r && tmr_done) begin
			done_nxt = 1'b1;
			tend_nxt = 1'b1;
			failout_nxt = fail_r || erl_r || erh_r || (lat_in_arr && lat_prot);
			if (!fail_r && !erl_r && !erh_r) begin
				if (lat_in_arr && !lat_prot) begin
					mem_we = 1'b1; // R16
				end else if (lat_in_nvr) begin
					nvr_nxt = nvr_r & lat_data_r; // R15 R16
				end
			end
			if (auto_r) begin
				pgm_nxt = 1'b0; // R12
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			latch_r <= 1'b0;
			pgm_r <= 1'b0;
			auto_r <= 1'b0;
			erl_r <= 1'b0;
			erh_r <= 1'b0;
			lat_addr_r <= '0;
			lat_data_r <= ebp_pkg::ERASED_BYTE;
			lat_valid_r <= 1'b0;
			fail_r <= 1'b0;
			rdata_r <= ebp_pkg::ZERO_BYTE;
			done_r <= 1'b0;
			failout_r <= 1'b0;
			tend_r <= 1'b0;
			nvr_r <= ebp_pkg::NVR_RESET;
		end else if (ce) begin
			latch_r <= latch_nxt;
			pgm_r <= pgm_nxt;
			auto_r <= auto_nxt;
			erl_r <= erl_nxt;
			erh_r <= erh_nxt;
			lat_addr_r <= lat_addr_nxt;
			lat_data_r <= lat_data_nxt;
			lat_valid_r <= lat_valid_nxt;
			fail_r <= fail_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
			failout_r <= failout_nxt;
			tend_r <= tend_nxt;
			nvr_r <= nvr_nxt;
		end
	end

	// the array models erased cells after reset; there is no erase path here
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < ebp_pkg::ARRAY_BYTES; i++) begin
				mem_r[i] <= ebp_pkg::ERASED_BYTE;
			end
		end else if (ce && mem_we) begin
			mem_r[lat_idx] <= mem_r[lat_idx] & lat_data_r; // R15
		end
	end

	assign bus.rdata = rdata_r;
	assign hv_on = pgm_r;
	assign prog_done = done_r;
	assign prog_fail = failout_r;
	assign nv_config = nvr_r;
endmodule : ebp_dev
`default_nettype wire

// File: rtl/ebp_cpu.sv
/*
 ebp_cpu: controller end; runs one byte-program sequence on the memory bus per order.
 Assumes software on the plain register port and the array end on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ebp_cpu (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	ebp_if.cpu bus,
	input wire logic [ebp_pkg::SW_ADDR_W-1:0] sw_addr,
	input wire logic [ebp_pkg::SW_DATA_W-1:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [ebp_pkg::SW_DATA_W-1:0] sw_rdata
);
	localparam int DW = ebp_pkg::DATA_W;
	localparam int AW = ebp_pkg::ADDR_W;

	ebp_pkg::ebp_hstate_e st_r, st_nxt;
	logic [AW-1:0] tgt_r, tgt_nxt;
	logic [DW-1:0] dat_r, dat_nxt;
	logic auto_r, auto_nxt;
	logic done_r, done_nxt;
	logic [AW-1:0] addr_r, addr_nxt;
	logic [DW-1:0] wdata_r, wdata_nxt;
	logic wr_r, wr_nxt;
	logic rd_r, rd_nxt;
	logic [ebp_pkg::SW_DATA_W-1:0] swr_r, swr_nxt;
	logic tmr_load;
	logic [ebp_pkg::TMR_W-1:0] tmr_len;
	logic tmr_done;
	logic [DW-1:0] ctl_lat;

	ebp_timer u_timer (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.load(tmr_load),
		.abort(1'b0),
		.len(tmr_len),
		.done(tmr_done)
	);

	always_comb begin
		ctl_lat = ebp_pkg::ZERO_BYTE;
		ctl_lat[ebp_pkg::BIT_LAT] = 1'b1; // R01
		ctl_lat[ebp_pkg::BIT_AUTO] = auto_r; // R02
	end

	always_comb begin
		st_nxt = st_r;
		tgt_nxt = tgt_r;
		dat_nxt = dat_r;
		auto_nxt = auto_r;
		done_nxt = done_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		wr_nxt = 1'b0;
		rd_nxt = 1'b0;
		swr_nxt = swr_r;
		tmr_load = 1'b0;
		tmr_len = ebp_pkg::PROGRAM_CYCLES;
		if (sw_rd) begin
			swr_nxt = '0;
			unique case (sw_addr)
				ebp_pkg::SW_TARGET: swr_nxt = tgt_r;
				ebp_pkg::SW_DATA: swr_nxt[DW-1:0] = dat_r;
				ebp_pkg::SW_CMD: swr_nxt[ebp_pkg::CMD_AUTO] = auto_r;
				ebp_pkg::SW_STATUS: begin
					swr_nxt[ebp_pkg::ST_BUSY] = (st_r != ebp_pkg::HS_IDLE);
					swr_nxt[ebp_pkg::ST_DONE] = done_r;
				end
			endcase
		end
		unique case (st_r)
			ebp_pkg::HS_IDLE: begin
				// orders are ignored while a sequence runs
				if (sw_wr && sw_addr == ebp_pkg::SW_TARGET) begin
					tgt_nxt = sw_wdata;
				end
				if (sw_wr && sw_addr == ebp_pkg::SW_DATA) begin
					dat_nxt = sw_wdata[DW-1:0];
				end
				if (sw_wr && sw_addr == ebp_pkg::SW_CMD && sw_wdata[ebp_pkg::CMD_GO]) begin
					auto_nxt = sw_wdata[ebp_pkg::CMD_AUTO];
					done_nxt = 1'b0;
					addr_nxt = ebp_pkg::CTRL_ADDR;
					wdata_nxt = ebp_pkg::ZERO_BYTE;
					wdata_nxt[ebp_pkg::BIT_LAT] = 1'b1; // R01
					wdata_nxt[ebp_pkg::BIT_AUTO] = sw_wdata[ebp_pkg::CMD_AUTO]; // R02
					wr_nxt = 1'b1;
					st_nxt = ebp_pkg::HS_DATA;
				end
			end
			ebp_pkg::HS_DATA: begin
				addr_nxt = tgt_r;
				wdata_nxt = dat_r; // R17
				wr_nxt = 1'b1;
				st_nxt = ebp_pkg::HS_PGM;
			end
			ebp_pkg::HS_PGM: begin
				addr_nxt = ebp_pkg::CTRL_ADDR;
				wdata_nxt = ctl_lat;
				wdata_nxt[ebp_pkg::BIT_PGM] = 1'b1;
				wr_nxt = 1'b1;
				tmr_load = !auto_r;
				st_nxt = auto_r ? ebp_pkg::HS_POLL : ebp_pkg::HS_WAITP;
			end
			ebp_pkg::HS_WAITP: begin
				if (tmr_done) begin
					wdata_nxt = ctl_lat; // R11
					wr_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_len = ebp_pkg::FALL_CYCLES;
					st_nxt = ebp_pkg::HS_WAITF;
				end
			end
			ebp_pkg::HS_WAITF: begin
				if (tmr_done) begin
					st_nxt = ebp_pkg::HS_CLRL; // R11
				end
			end
			ebp_pkg::HS_POLL: begin
				// only the control register is read while high voltage is up
				addr_nxt = ebp_pkg::CTRL_ADDR; // R06 R10
				rd_nxt = 1'b1;
				st_nxt = ebp_pkg::HS_POLLW;
			end
			ebp_pkg::HS_POLLW: begin
				st_nxt = ebp_pkg::HS_POLLR;
			end
			ebp_pkg::HS_POLLR: begin
				st_nxt = bus.rdata[ebp_pkg::BIT_PGM] ? ebp_pkg::HS_POLL : ebp_pkg::HS_CLRL; // R12
			end
			ebp_pkg::HS_CLRL: begin
				addr_nxt = ebp_pkg::CTRL_ADDR;
				wdata_nxt = ebp_pkg::ZERO_BYTE;
				wr_nxt = 1'b1;
				st_nxt = ebp_pkg::HS_END;
			end
			ebp_pkg::HS_END: begin
				done_nxt = 1'b1;
				st_nxt = ebp_pkg::HS_IDLE;
			end
			default: st_nxt = ebp_pkg::HS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ebp_pkg::HS_IDLE;
			tgt_r <= '0;
			dat_r <= ebp_pkg::ZERO_BYTE;
			auto_r <= 1'b0;
			done_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= ebp_pkg::ZERO_BYTE;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			swr_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
			tgt_r <= tgt_nxt;
			dat_r <= dat_nxt;
			auto_r <= auto_nxt;
			done_r <= done_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			swr_r <= swr_nxt;
		end
	end

	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign bus.wr = wr_r;
	assign bus.rd = rd_r;
	assign sw_rdata = swr_r;
endmodule : ebp_cpu
`default_nettype wire

// File: verif/ebp_checker.sv
/*
 ebp_checker: watches the memory bus between the controller end and the array end.
 Assumes one mclk domain; hv_on and prog_done come from the array end on that bus.
*/
`timescale 1ns/1ps
`default_nettype none
module ebp_checker (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [ebp_pkg::ADDR_W-1:0] addr,
	input wire logic [ebp_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [ebp_pkg::DATA_W-1:0] rdata,
	input wire logic hv_on,
	input wire logic prog_done
);
	logic [ebp_pkg::TMR_W-1:0] cnt_r, cnt_nxt;
	logic hv_r, auto_r, auto_nxt, ctl_wr, pgm_wr;
	assign ctl_wr = wr && addr == ebp_pkg::CTRL_ADDR;
	assign pgm_wr = ctl_wr && wdata[ebp_pkg::BIT_PGM] && wdata[ebp_pkg::BIT_LAT];
	// cycles since hv_on last changed; saturates so a long idle never wraps
	always_comb begin
		cnt_nxt = (hv_on != hv_r) ? '0 : cnt_r + ((cnt_r == '1) ? '0 : ebp_pkg::TMR_ONE);
		auto_nxt = ctl_wr ? wdata[ebp_pkg::BIT_AUTO] : auto_r;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			hv_r <= 1'b0;
			auto_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			hv_r <= hv_on;
			auto_r <= auto_nxt;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	sequence s_pgm_write;
		ctl_wr && wdata[ebp_pkg::BIT_PGM];
	endsequence
	sequence s_hv_end;
		$fell(hv_on);
	endsequence
	a_pgm_cause: assert property ($rose(hv_on) |-> $past(pgm_wr))
		else $error("hv_on rose without a program write");
	a_auto_step: assert property (s_pgm_write |-> wdata[ebp_pkg::BIT_AUTO] == auto_r)
		else $error("auto bit not chosen in the latch step");
	a_auto_stop: assert property (s_hv_end ##0 auto_r |-> cnt_r >= ebp_pkg::AUTO_CYCLES - 12'h003
		&& cnt_r <= ebp_pkg::AUTO_CYCLES + 12'h003 && cnt_r < ebp_pkg::PROGRAM_CYCLES)
		else $error("automatic stop at wrong time");
	a_manual_hold: assert property (s_hv_end ##0 !auto_r |-> cnt_r >= ebp_pkg::PROGRAM_CYCLES - 12'h004)
		else $error("manual program cut short");
	a_fall_wait: assert property (ctl_wr && !wdata[ebp_pkg::BIT_LAT] && !auto_r
		|-> !hv_on && cnt_r >= ebp_pkg::FALL_CYCLES - 12'h004)
		else $error("latch cleared before voltage fall");
	a_done_pulse: assert property (prog_done |=> !prog_done)
		else $error("prog_done longer than one cycle");
	a_poll_reply: assert property (rd && addr == ebp_pkg::CTRL_ADDR
		|=> rdata[ebp_pkg::BIT_PGM] == $past(hv_on) && rdata[7:5] == 3'h0)
		else $error("control read disagrees with hv_on");
	a_no_read_pgm: assert property (hv_on && rd |-> addr == ebp_pkg::CTRL_ADDR)
		else $error("array read while programming");
endmodule : ebp_checker
`default_nettype wire

// File: verif/test_eeprom_byte_program_sequencer.sv
/*
 test_eeprom_byte_program_sequencer: controller end against array end, plus a second array end
 driven directly by the bench for refused and failing sequences. Assumes mclk at 250 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_byte_program_sequencer;
	logic mclk, nrst, ce, sw_wr, sw_rd, hv_a, done_a, fail_a, hv_b, done_b, fail_b;
	logic [1:0] sw_addr;
	logic [15:0] sw_wdata, sw_rdata;
	logic [3:0] blk_b;
	logic [7:0] nvc_a, nvc_b;
	int err_count, comparisons;
	ebp_if bus_a ();
	ebp_if bus_b ();
	ebp_cpu ebp_cpu_inst (.mclk(mclk), .nrst(nrst), .ce(ce), .bus(bus_a), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	ebp_dev ebp_dev_inst (.mclk(mclk), .nrst(nrst), .ce(ce), .bus(bus_a), .blk_protect(4'h0),
		.hv_on(hv_a), .prog_done(done_a), .prog_fail(fail_a), .nv_config(nvc_a));
	ebp_dev ebp_dev_inst_b (.mclk(mclk), .nrst(nrst), .ce(ce), .bus(bus_b), .blk_protect(blk_b),
		.hv_on(hv_b), .prog_done(done_b), .prog_fail(fail_b), .nv_config(nvc_b));
	ebp_checker ebp_checker_inst (.mclk(mclk), .nrst(nrst), .addr(bus_a.addr), .wdata(bus_a.wdata),
		.wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata), .hv_on(hv_a), .prog_done(done_a));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic bw(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_b.addr <= a;
		bus_b.wdata <= d;
		bus_b.wr <= 1'b1;
		@(posedge mclk);
		bus_b.wr <= 1'b0;
		// let the edge's updates settle before a caller looks at outputs
		#1;
	endtask : bw
	task automatic br(input logic [15:0] a, input logic [7:0] exp, input string name);
		@(posedge mclk);
		bus_b.addr <= a;
		bus_b.rd <= 1'b1;
		@(posedge mclk);
		bus_b.rd <= 1'b0;
		#1;
		chk(name, {8'h00, bus_b.rdata}, {8'h00, exp});
	endtask : br
	task automatic sww(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
		#1;
	endtask : sww
	task automatic wait_done;
		int n;
		n = 0;
		while (done_b !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("done_b", {15'h0, n < 3000}, 16'h0001);
	endtask : wait_done
	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		bw(ebp_pkg::CTRL_ADDR, 8'h12);
		bw(a, d);
		bw(ebp_pkg::CTRL_ADDR, 8'h13);
		wait_done();
		bw(ebp_pkg::CTRL_ADDR, 8'h00);
	endtask : prog
	task automatic t_cpu(input logic [15:0] cmd, input logic [15:0] tgt);
		logic [15:0] st;
		int n;
		sww(ebp_pkg::SW_TARGET, tgt);
		sww(ebp_pkg::SW_DATA, 16'h00F0);
		sww(ebp_pkg::SW_CMD, cmd);
		n = 0;
		st = 16'h0001;
		while (st[ebp_pkg::ST_BUSY] !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			sw_addr <= ebp_pkg::SW_STATUS;
			sw_rd <= 1'b1;
			@(posedge mclk);
			sw_rd <= 1'b0;
			#1;
			st = sw_rdata;
			n++;
		end
		chk("status", st, 16'h0002);
		chk("fail_a", {15'h0, fail_a}, 16'h0000);
	endtask : t_cpu
	task automatic t_latch;
		bw(ebp_pkg::CTRL_ADDR, 8'h12);
		bw(16'h0810, 8'h3C);
		bw(16'h0811, 8'hF5);
		bw(16'h1000, 8'h00);
		br(16'h0811, 8'hF5, "latched");
		bw(ebp_pkg::CTRL_ADDR, 8'h13);
		chk("hv_b", {15'h0, hv_b}, 16'h0001);
		wait_done();
		chk("fail_b", {15'h0, fail_b}, 16'h0000);
		bw(ebp_pkg::CTRL_ADDR, 8'h00);
		br(16'h0811, 8'hF5, "byte");
		br(16'h0810, 8'hFF, "older");
	endtask : t_latch
	task automatic t_refuse;
		bw(ebp_pkg::CTRL_ADDR, 8'h01);
		chk("hv_nolat", {15'h0, hv_b}, 16'h0000);
		bw(ebp_pkg::CTRL_ADDR, 8'h02);
		bw(ebp_pkg::CTRL_ADDR, 8'h03);
		chk("hv_nowr", {15'h0, hv_b}, 16'h0000);
		bw(16'h0811, 8'h0F);
		bw(ebp_pkg::CTRL_ADDR, 8'h03);
		chk("hv_on", {15'h0, hv_b}, 16'h0001);
		repeat (ebp_pkg::PROGRAM_CYCLES) @(posedge mclk);
		bw(ebp_pkg::CTRL_ADDR, 8'h00);
		br(ebp_pkg::CTRL_ADDR, 8'h02, "ctrl_both");
		repeat (ebp_pkg::FALL_CYCLES) @(posedge mclk);
		bw(ebp_pkg::CTRL_ADDR, 8'h00);
		br(ebp_pkg::CTRL_ADDR, 8'h00, "ctrl_off");
		chk("fail_man", {15'h0, fail_b}, 16'h0000);
		br(16'h0811, 8'h05, "and_byte");
	endtask : t_refuse
	task automatic t_fail;
		bw(ebp_pkg::CTRL_ADDR, 8'h12);
		bw(16'h0812, 8'h00);
		bw(ebp_pkg::CTRL_ADDR, 8'h13);
		br(16'h0812, 8'h00, "rd_pgm");
		wait_done();
		chk("fail_rd", {15'h0, fail_b}, 16'h0001);
		bw(ebp_pkg::CTRL_ADDR, 8'h00);
		br(16'h0812, 8'hFF, "no_commit");
		// block 0 protected: the byte must stay erased, the config still programs
		blk_b <= 4'h1;
		prog(16'h0820, 8'h00);
		br(16'h0820, 8'hFF, "protected");
		chk("fail_prot", {15'h0, fail_b}, 16'h0001);
		prog(ebp_pkg::NVR_ADDR, 8'hA5);
		chk("nv_config", {8'h00, nvc_b}, 16'h00A5);
		blk_b <= 4'h0;
		// an erase bit left set in the latch step must spoil the program cycle
		bw(ebp_pkg::CTRL_ADDR, 8'h16);
		br(ebp_pkg::CTRL_ADDR, 8'h16, "ctrl_erase");
		bw(16'h0930, 8'h00);
		bw(ebp_pkg::CTRL_ADDR, 8'h17);
		wait_done();
		chk("fail_erase", {15'h0, fail_b}, 16'h0001);
		bw(ebp_pkg::CTRL_ADDR, 8'h00);
		br(16'h0930, 8'hFF, "erase_set");
	endtask : t_fail
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (40000) @(posedge mclk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		sw_addr = 2'h0;
		sw_wdata = 16'h0000;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		blk_b = 4'h0;
		bus_b.addr = 16'h0000;
		bus_b.wdata = 8'h00;
		bus_b.wr = 1'b0;
		bus_b.rd = 1'b0;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		chk("nvc_rst", {8'h00, nvc_a}, 16'h00FF);
		chk("hv_rst", {14'h0, hv_a, hv_b}, 16'h0000);
		br(16'h0800, 8'hFF, "erased");
		// each controller run targets a fresh byte so no zero bit is programmed twice
		t_cpu(16'h0003, 16'h0805);
		t_cpu(16'h0001, 16'h0806);
		t_latch();
		t_refuse();
		t_fail();
		tally_and_finish();
	end
endmodule : test_eeprom_byte_program_sequencer
`default_nettype wire
